// *** hdl/msi_vpd_capability_regs.sv ***
/*
  MSI, VPD and power-management data capability registers of one switch port,
  with the MSI/INTx request logic and the VPD table access handshake.
  Assumes configuration accesses, side-band preload, interrupt events and the EEPROM
  controller all come from logic on CLK; the port role is fixed by a parameter.
*/
// Notes on behaviour
// - The power-management data byte in bits 31:24 is read-only, resets to zero, preloads.
// - A downstream port shows the MSI structure with identifier 05h.
// - Both the MSI and VPD structures point on to the vendor structure at 64h.
// - MSI enable resets clear; clear means INTx only, set means MSI only and no INTx.
// - The 64-bit address capable flag reads one.
// - The low message address is a writable dword target, bits 1:0 reserved, reset zero.
// - The upper message address is writable, resets to zero and forms the top of the MSI target.
// - An upstream port shows the VPD structure with identifier 03h.
// - A writable six-bit VPD dword address, reset to zero, selects the table location.
// - A writable VPD write-enable bit, reset to zero, gates writes to the table.
// - Writing the flag as zero starts a read; it stays zero and turns one when the cycle ends.
// - Writing the flag as one starts a write; it stays one and turns zero when the cycle ends.
// - Reading the Vpd_transfer_word returns the last word fetched from the table or written by software.
// - Writing the Vpd_transfer_word supplies the word to store into the table.
`include "msi_vpd_caps_regs.svh"
`default_nettype none

module msi_vpd_capability_regs
  import msi_vpd_caps_pkg::*;
#(
  parameter bit UPSTREAM_PORT = 1'b0
)(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CFG_REQ,
  input  wire logic        CFG_WRITE,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic             CFG_ACK,
  output logic [31:0]      CFG_RDATA,
  input  wire logic        PM_DATA_LOAD,
  input  wire logic [7:0]  PM_DATA_VALUE,
  input  wire logic        INT_EVENT,
  input  wire logic        INTX_CLEAR,
  output logic             INTX_ASSERT,
  output logic             MSI_REQ,
  output logic [63:0]      MSI_ADDR,
  output logic [15:0]      MSI_DATA,
  input  wire logic        MSI_ACK,
  output logic             EE_REQ,
  output logic             EE_WRITE,
  output logic [5:0]       EE_ADDR,
  output logic [31:0]      EE_WDATA,
  input  wire logic        EE_DONE,
  input  wire logic [31:0] EE_RDATA
);

  localparam bit HAS_MSI = !UPSTREAM_PORT;
  localparam bit HAS_VPD = UPSTREAM_PORT;

  // Merges the enabled byte lanes of a write into the old value.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  lanes);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  logic [7:0]  pm_data_reg;
  logic        msi_en_reg;
  logic [2:0]  msi_mme_reg;
  logic [29:0] msi_addr_lo_reg;
  logic [31:0] msi_addr_hi_reg;
  logic [15:0] msi_data_reg;
  logic [5:0]  vpd_addr_reg;
  logic        vpd_wen_reg;
  logic        vpd_flag_reg;
  logic        vpd_busy_reg;
  logic [31:0] vpd_data_reg;
  logic [31:0] read_next;
  logic        wr;
  logic        vpd_start;
  logic        seq_done;
  logic        seq_done_read;
  logic [31:0] seq_rdata;
  logic [31:0] msi_ctrl_word;
  logic [31:0] vpd_ctrl_word;
  logic [31:0] msi_ctrl_new;
  logic [31:0] vpd_ctrl_new;
  logic [31:0] addr_lo_new;
  logic [31:0] data_new;
  vpd_cmd_type vpd_cmd;

  assign wr = CFG_REQ && CFG_WRITE;

  assign msi_ctrl_word = {8'h00, `MSI_64BIT_CAPABLE, msi_mme_reg, `MSI_MMC_VALUE, msi_en_reg,
                          `CAP_NEXT_VENDOR, `CAP_ID_MSI};
  assign vpd_ctrl_word = {vpd_flag_reg, vpd_wen_reg, 6'h00, vpd_addr_reg, 2'h0,
                          `CAP_NEXT_VENDOR, `CAP_ID_VPD};
  assign msi_ctrl_new  = merge_bytes(msi_ctrl_word, CFG_WDATA, CFG_BE);
  assign vpd_ctrl_new  = merge_bytes(vpd_ctrl_word, CFG_WDATA, CFG_BE);
  assign addr_lo_new   = merge_bytes({msi_addr_lo_reg, 2'h0}, CFG_WDATA, CFG_BE);
  assign data_new      = merge_bytes({16'h0, msi_data_reg}, CFG_WDATA, CFG_BE);

  // Only a write touching the flag's byte starts a cycle, and only while none is running.
  assign vpd_start = HAS_VPD && wr && CFG_ADDR == `OFF_VPD_CAP && CFG_BE[`BYTE3_LANE]
                     && !vpd_busy_reg;

  always_comb begin
    read_next = 32'h0;
    case (CFG_ADDR)
      `OFF_PM_DATA:     read_next = {pm_data_reg, 24'h0};
      `OFF_MSI_CAP:     read_next = HAS_MSI ? msi_ctrl_word : 32'h0;
      `OFF_MSI_ADDR_LO: read_next = HAS_MSI ? {msi_addr_lo_reg, 2'h0} : 32'h0;
      `OFF_MSI_ADDR_HI: read_next = HAS_MSI ? msi_addr_hi_reg : 32'h0;
      `OFF_MSI_DATA:    read_next = HAS_MSI ? {16'h0, msi_data_reg} : 32'h0;
      `OFF_VPD_CAP:     read_next = HAS_VPD ? vpd_ctrl_word : 32'h0;
      `OFF_VPD_DATA:    read_next = HAS_VPD ? vpd_data_reg : 32'h0;
      default:          read_next = 32'h0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CFG_ACK   <= 1'b0;
      CFG_RDATA <= 32'h0;
    end else begin
      CFG_ACK   <= CFG_REQ;
      CFG_RDATA <= (CFG_REQ && !CFG_WRITE) ? read_next : 32'h0;
    end
  end

  // Configuration writes cannot reach this byte; only the side band reloads it.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pm_data_reg <= `PM_DATA_RESET;
    end else if (PM_DATA_LOAD) begin
      pm_data_reg <= PM_DATA_VALUE;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      msi_en_reg      <= 1'b0;
      msi_mme_reg     <= 3'h0;
      msi_addr_lo_reg <= `MSI_ADDR_RESET;
      msi_addr_hi_reg <= `MSI_HI_RESET;
      msi_data_reg    <= `MSI_DATA_RESET;
    end else if (HAS_MSI && wr) begin
      case (CFG_ADDR)
        `OFF_MSI_CAP: begin
          msi_en_reg  <= msi_ctrl_new[`MSI_EN_BIT];
          msi_mme_reg <= msi_ctrl_new[`MSI_MME_LSB +: 3];
        end
        `OFF_MSI_ADDR_LO: msi_addr_lo_reg <= addr_lo_new[31:`MSI_ADDR_LSB];
        `OFF_MSI_ADDR_HI: msi_addr_hi_reg <= merge_bytes(msi_addr_hi_reg, CFG_WDATA,
                                                         CFG_BE);
        `OFF_MSI_DATA:    msi_data_reg <= data_new[15:0];
        default: begin
        end
      endcase
    end
  end

  // An event meeting an acknowledge or a clear in the same cycle is kept, not lost.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MSI_REQ  <= 1'b0;
      MSI_ADDR <= 64'h0;
      MSI_DATA <= 16'h0;
    end else if (msi_en_reg && INT_EVENT) begin
      MSI_REQ  <= 1'b1;
      MSI_ADDR <= {`MSI_64BIT_CAPABLE ? msi_addr_hi_reg : 32'h0,
                   msi_addr_lo_reg, 2'h0};
      MSI_DATA <= msi_data_reg;
    end else if (MSI_ACK || !msi_en_reg) begin
      MSI_REQ <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      INTX_ASSERT <= 1'b0;
    end else if (msi_en_reg) begin
      INTX_ASSERT <= 1'b0;
    end else if (INT_EVENT) begin
      INTX_ASSERT <= 1'b1;
    end else if (INTX_CLEAR) begin
      INTX_ASSERT <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vpd_addr_reg <= `VPD_ADDR_RESET;
      vpd_wen_reg  <= 1'b0;
    end else if (HAS_VPD && wr && CFG_ADDR == `OFF_VPD_CAP) begin
      vpd_addr_reg <= vpd_ctrl_new[`VPD_ADDR_LSB +: 6];
      vpd_wen_reg  <= vpd_ctrl_new[`VPD_WEN_BIT];
    end
  end

  // The flag holds the requested direction while busy and flips when the cycle ends.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vpd_flag_reg <= 1'b0;
      vpd_busy_reg <= 1'b0;
    end else if (vpd_start) begin
      vpd_flag_reg <= CFG_WDATA[`VPD_FLAG_BIT];
      vpd_busy_reg <= 1'b1;
    end else if (seq_done) begin
      vpd_flag_reg <= seq_done_read;
      vpd_busy_reg <= 1'b0;
    end
  end

  // A fetched word overrides a software write landing in the same cycle.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      vpd_data_reg <= `VPD_DATA_RESET;
    end else if (seq_done && seq_done_read) begin
      vpd_data_reg <= seq_rdata;
    end else if (HAS_VPD && wr && CFG_ADDR == `OFF_VPD_DATA) begin
      vpd_data_reg <= merge_bytes(vpd_data_reg, CFG_WDATA, CFG_BE);
    end
  end

  always_comb begin
    vpd_cmd.write        = CFG_WDATA[`VPD_FLAG_BIT];
    vpd_cmd.write_enable = vpd_ctrl_new[`VPD_WEN_BIT];
    vpd_cmd.addr         = vpd_ctrl_new[`VPD_ADDR_LSB +: 6];
    vpd_cmd.wdata        = vpd_data_reg;
  end

  vpd_eeprom_sequencer u_sequencer (
    .clk           (CLK),
    .rstn          (RSTN),
    .start         (vpd_start),
    .cmd           (vpd_cmd),
    .done          (seq_done),
    .done_was_read (seq_done_read),
    .rdata         (seq_rdata),
    .ee_req        (EE_REQ),
    .ee_write      (EE_WRITE),
    .ee_addr       (EE_ADDR),
    .ee_wdata      (EE_WDATA),
    .ee_done       (EE_DONE),
    .ee_rdata      (EE_RDATA)
  );

endmodule

`default_nettype wire

// *** hdl/msi_vpd_caps_regs.svh ***
/*
  Offsets, field positions, fixed codes and reset values of the port's MSI, VPD and
  power-management data registers. Assumes byte offsets within configuration space.
*/
`ifndef MSI_VPD_CAPS_REGS_SVH
`define MSI_VPD_CAPS_REGS_SVH

`define OFF_PM_DATA        8'h44
`define OFF_MSI_CAP        8'h4C
`define OFF_MSI_ADDR_LO    8'h50
`define OFF_MSI_ADDR_HI    8'h54
`define OFF_MSI_DATA       8'h58
`define OFF_VPD_CAP        8'h5C
`define OFF_VPD_DATA       8'h60

`define CAP_ID_MSI         8'h05
`define CAP_ID_VPD         8'h03
`define CAP_NEXT_VENDOR    8'h64
`define MSI_MMC_VALUE      3'h0
`define MSI_64BIT_CAPABLE  1'h1

`define PM_DATA_RESET      8'h00
`define MSI_ADDR_RESET     30'h0
`define MSI_HI_RESET       32'h0
`define MSI_DATA_RESET     16'h0
`define VPD_ADDR_RESET     6'h0
`define VPD_DATA_RESET     32'h0

`define PM_DATA_LSB        24
`define MSI_EN_BIT         16
`define MSI_MMC_LSB        17
`define MSI_MME_LSB        20
`define MSI_64_BIT         23
`define MSI_ADDR_LSB       2
`define VPD_ADDR_LSB       18
`define VPD_WEN_BIT        30
`define VPD_FLAG_BIT       31
`define BYTE2_LANE         2
`define BYTE3_LANE         3

`endif

// *** hdl/msi_vpd_caps_pkg.sv ***
/*
  Types shared by the capability register block and its VPD sequencer.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package msi_vpd_caps_pkg;

  typedef struct packed {
    logic        write;
    logic        write_enable;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } vpd_cmd_type;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_WAIT = 1'b1
  } seq_state_type;

endpackage

`default_nettype wire

// *** hdl/vpd_eeprom_sequencer.sv ***
/*
  Runs one VPD table cycle against the EEPROM controller: request held until done.
  Assumes the EEPROM controller shares CLK and answers with a one-cycle done pulse.
*/
`default_nettype none

module vpd_eeprom_sequencer
  import msi_vpd_caps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire vpd_cmd_type cmd,
  output logic             done,
  output logic             done_was_read,
  output logic [31:0]      rdata,
  output logic             ee_req,
  output logic             ee_write,
  output logic [5:0]       ee_addr,
  output logic [31:0]      ee_wdata,
  input  wire logic        ee_done,
  input  wire logic [31:0] ee_rdata
);

  seq_state_type state_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= SEQ_IDLE;
      done          <= 1'b0;
      done_was_read <= 1'b0;
      rdata         <= 32'h0;
      ee_req        <= 1'b0;
      ee_write      <= 1'b0;
      ee_addr       <= 6'h0;
      ee_wdata      <= 32'h0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        SEQ_IDLE: begin
          if (start) begin
            done_was_read <= !cmd.write;
            // A locked write never reaches the EEPROM but still finishes, so the flag returns.
            if (cmd.write && !cmd.write_enable) begin
              done <= 1'b1;
            end else begin
              ee_req    <= 1'b1;
              ee_write  <= cmd.write;
              ee_addr   <= cmd.addr;
              ee_wdata  <= cmd.wdata;
              state_reg <= SEQ_WAIT;
            end
          end
        end
        SEQ_WAIT: begin
          if (ee_done) begin
            ee_req    <= 1'b0;
            done      <= 1'b1;
            state_reg <= SEQ_IDLE;
            if (!ee_write) begin
              rdata <= ee_rdata;
            end
          end
        end
        default: begin
          state_reg <= SEQ_IDLE;
          ee_req    <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// *** verification/msi_vpd_capability_regs_checker.sv ***
/* Port assertions for the capability register block, bound to every instance.
   Assumes one clock domain and the role parameter handed on by the bind. */
`default_nettype none
module msi_vpd_capability_regs_checker #(parameter bit UPSTREAM_PORT = 1'b0)(
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CFG_REQ,
  input wire logic        CFG_WRITE,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic        CFG_ACK,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        INT_EVENT,
  input wire logic        INTX_ASSERT,
  input wire logic        MSI_REQ,
  input wire logic [63:0] MSI_ADDR,
  input wire logic [15:0] MSI_DATA,
  input wire logic        MSI_ACK,
  input wire logic        EE_REQ,
  input wire logic [5:0]  EE_ADDR,
  input wire logic        EE_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire rd = CFG_REQ && !CFG_WRITE;
  chk_cfg_ack: assert property (CFG_REQ |=> CFG_ACK)
    else $error("config access not acknowledged");
  chk_pm_low_zero: assert property (rd && CFG_ADDR == 8'h44 |=> CFG_RDATA[23:0] == 24'h0)
    else $error("pm data dword low bits not zero");
  chk_msi_id_next: assert property (!UPSTREAM_PORT && rd && CFG_ADDR == 8'h4C
    |=> CFG_RDATA[15:0] == 16'h6405 && CFG_RDATA[23] && CFG_RDATA[19:17] == 3'h0)
    else $error("msi header wrong");
  chk_vpd_id_next: assert property (UPSTREAM_PORT && rd && CFG_ADDR == 8'h5C
    |=> CFG_RDATA[15:0] == 16'h6403) else $error("vpd header wrong");
  chk_msi_no_intx: assert property (MSI_REQ |-> !INTX_ASSERT)
    else $error("intx raised beside msi");
  chk_msi_align: assert property (MSI_REQ |-> MSI_ADDR[1:0] == 2'h0)
    else $error("msi address not dword aligned");
  chk_msi_req_hold: assert property (MSI_REQ && !MSI_ACK && !INT_EVENT
    |=> MSI_REQ && $stable(MSI_DATA)) else $error("msi request dropped or changed");
  chk_ee_req_hold: assert property (EE_REQ && !EE_DONE |=> EE_REQ && $stable(EE_ADDR))
    else $error("eeprom request dropped early");
  chk_ee_release: assert property (EE_REQ && EE_DONE |=> !EE_REQ)
    else $error("eeprom request held after done");
  cover property (MSI_REQ && MSI_ACK);
  cover property (EE_REQ && EE_DONE);
  cover property (INTX_ASSERT);
endmodule
bind msi_vpd_capability_regs msi_vpd_capability_regs_checker #(.UPSTREAM_PORT(UPSTREAM_PORT))
  chk (.CLK, .RSTN, .CFG_REQ, .CFG_WRITE, .CFG_ADDR, .CFG_ACK, .CFG_RDATA, .INT_EVENT,
  .INTX_ASSERT, .MSI_REQ, .MSI_ADDR, .MSI_DATA, .MSI_ACK, .EE_REQ, .EE_ADDR, .EE_DONE);
`default_nettype wire

// *** verification/vpd_eeprom_model.sv ***
/* Behavioural EEPROM controller answering VPD table cycles after lat extra cycles.
   Assumes it shares the block's clock; table words start as A500_00xx. */
`default_nettype none
module vpd_eeprom_model (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [5:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  lat,
  output logic            done,
  output logic [31:0]     rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [64];
  logic [3:0]  cnt;
  // Read data toggles outside done so a capture one cycle late sees the inverted word.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
      done <= 1'b0;
      rdata <= 32'h0;
      for (int i = 0; i < 64; i++) mem[i] <= 32'hA5000000 + i;
    end else begin
      done <= 1'b0;
      rdata <= ~rdata;
      if (req && !done) begin
        cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
        if (cnt == lat) begin
          done <= 1'b1;
          rdata <= mem[addr];
          if (wr) mem[addr] <= wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/msi_vpd_capability_regs_test.sv ***
/* Self-checking bench: a downstream and an upstream instance share one config bus.
   Assumes the EEPROM model answers the upstream instance only. */
`default_nettype none
module msi_vpd_capability_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, req, wr, pm_ld, ev, iclr, mack, ack_d, ack_u, intx;
  logic        msi_req, ee_req, ee_wr, ee_done, ee_seen;
  logic [7:0]  addr, pm_val;
  logic [3:0]  be, lat;
  logic [5:0]  ee_addr;
  logic [15:0] msi_data;
  logic [31:0] wdata, rd_d, rd_u, q_d, q_u, ee_wd, ee_rd;
  logic [63:0] msi_addr;
  int          mismatches, checks_done;
  logic [7:0]  offs [8] = '{8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h60};
  logic [31:0] exp_d [8] = '{32'h0, 32'h0, 32'h00806405, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] exp_u [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00006403, 32'h0};
  msi_vpd_capability_regs #(.UPSTREAM_PORT(1'b0)) dut (.CLK(clk), .RSTN(rstn), .CFG_REQ(req),
    .CFG_WRITE(wr), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_ACK(ack_d),
    .CFG_RDATA(rd_d), .PM_DATA_LOAD(pm_ld), .PM_DATA_VALUE(pm_val), .INT_EVENT(ev),
    .INTX_CLEAR(iclr), .INTX_ASSERT(intx), .MSI_REQ(msi_req), .MSI_ADDR(msi_addr),
    .MSI_DATA(msi_data), .MSI_ACK(mack), .EE_REQ(), .EE_WRITE(), .EE_ADDR(), .EE_WDATA(),
    .EE_DONE(1'b0), .EE_RDATA(32'h0));
  msi_vpd_capability_regs #(.UPSTREAM_PORT(1'b1)) dut_up (.CLK(clk), .RSTN(rstn),
    .CFG_REQ(req), .CFG_WRITE(wr), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wdata),
    .CFG_ACK(ack_u), .CFG_RDATA(rd_u), .PM_DATA_LOAD(pm_ld), .PM_DATA_VALUE(pm_val),
    .INT_EVENT(ev), .INTX_CLEAR(iclr), .INTX_ASSERT(), .MSI_REQ(), .MSI_ADDR(), .MSI_DATA(),
    .MSI_ACK(mack), .EE_REQ(ee_req), .EE_WRITE(ee_wr), .EE_ADDR(ee_addr), .EE_WDATA(ee_wd),
    .EE_DONE(ee_done), .EE_RDATA(ee_rd));
  vpd_eeprom_model ee (.clk(clk), .rstn(rstn), .req(ee_req), .wr(ee_wr), .addr(ee_addr),
    .wdata(ee_wd), .lat(lat), .done(ee_done), .rdata(ee_rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (ee_req) ee_seen <= 1'b1;
  task automatic chk(input string n, input logic [63:0] e, s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    {req, wr, addr, wdata} = {1'b1, w, a, d};
    @(negedge clk);
    req = 1'b0;
    q_d = rd_d;
    q_u = rd_u;
    chk("cfg ack", 2'b11, {ack_d, ack_u});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  // Polling stands in for software waiting on the flag before reusing data.
  task automatic vpd_wait(input logic fin);
    for (int i = 0; i < 40; i++) begin
      cfg(1'b0, 8'h5C, 32'h0);
      if (q_u[31] === fin) return;
    end
    chk("vpd flag", fin, q_u[31]);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rstn, req, wr, addr, wdata, pm_ld, pm_val, ev, iclr, mack, ee_seen} = '0;
    be = 4'hF;
    lat = 4'h3;
    repeat (8) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    foreach (offs[i]) begin
      cfg(1'b0, offs[i], 32'h0);
      chk("down map", exp_d[i], q_d);
      chk("up map", exp_u[i], q_u);
    end
    $display("test reset_map finished");
    pm_val = 8'h5A;
    pulse(pm_ld);
    cfg(1'b1, 8'h44, 32'hFFFFFFFF);
    cfg(1'b0, 8'h44, 32'h0);
    chk("pm data", 32'h5A000000, q_d);
    $display("test pm_data finished");
    cfg(1'b1, 8'h50, 32'hFFFFFFFF);
    cfg(1'b1, 8'h54, 32'h12345678);
    cfg(1'b1, 8'h58, 32'hFFFFABCD);
    cfg(1'b0, 8'h50, 32'h0);
    chk("msi addr low", 32'hFFFFFFFC, q_d);
    chk("up msi hidden", 32'h0, q_u);
    cfg(1'b0, 8'h58, 32'h0);
    chk("msi data reg", 32'h0000ABCD, q_d);
    pulse(ev);
    chk("intx path", 2'b10, {intx, msi_req});
    pulse(iclr);
    chk("intx cleared", 1'b0, intx);
    cfg(1'b1, 8'h4C, 32'hFFFFFFFF);
    cfg(1'b0, 8'h4C, 32'h0);
    chk("msi control", 32'h00F16405, q_d);
    pulse(ev);
    chk("msi path", 2'b01, {intx, msi_req});
    chk("msi target", 64'h12345678FFFFFFFC, msi_addr);
    chk("msi payload", 16'hABCD, msi_data);
    pulse(mack);
    chk("msi retired", 1'b0, msi_req);
    $display("test msi finished");
    cfg(1'b1, 8'h5C, 32'h00140000);
    cfg(1'b0, 8'h5C, 32'h0);
    chk("vpd read busy", 32'h00146403, q_u);
    vpd_wait(1'b1);
    cfg(1'b0, 8'h60, 32'h0);
    chk("vpd read data", 32'hA5000005, q_u);
    lat = 4'h0;
    cfg(1'b1, 8'h60, 32'hDEADBEEF);
    cfg(1'b1, 8'h5C, 32'hC0280000);
    cfg(1'b0, 8'h5C, 32'h0);
    chk("vpd write busy", 32'hC0286403, q_u);
    vpd_wait(1'b0);
    cfg(1'b1, 8'h5C, 32'h00280000);
    vpd_wait(1'b1);
    cfg(1'b0, 8'h60, 32'h0);
    chk("vpd stored word", 32'hDEADBEEF, q_u);
    ee_seen = 1'b0;
    cfg(1'b1, 8'h5C, 32'h80300000);
    vpd_wait(1'b0);
    be = 4'h7;
    cfg(1'b1, 8'h5C, 32'h80040000);
    cfg(1'b0, 8'h5C, 32'h0);
    chk("vpd partial", 32'h00046403, q_u);
    chk("no table cycle", 1'b0, ee_seen);
    $display("test vpd finished");
    finish_test;
  end
  initial begin
    #100000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
